//--- shared/mla_regs.svh
// Purpose: Opcodes, cycle counts and register-file encodings for the transfer executor
// Assumes: Included by design files only
// Notes:   Definitions only
`ifndef MLA_REGS_SVH
`define MLA_REGS_SVH

// =====================================================================
// Opcodes
`define MLA_OP_LD_DEC    8'he2
`define MLA_OP_LD_INC    8'he3
`define MLA_OP_ST_DEC    8'hf2
`define MLA_OP_ST_INC    8'hf3
`define MLA_OP_WORD_RR   8'hc4
`define MLA_OP_WORD_IR   8'hc5
`define MLA_OP_WORD_IMM  8'hc6

// =====================================================================
// Cycle counts per instruction
`define MLA_CYC_LOAD     4'ha
`define MLA_CYC_STORE    4'he
`define MLA_CYC_WORD     4'h8
`define MLA_CYC_NONE     4'h0

// =====================================================================
// Register-file encodings
`define MLA_WORK_ESC     4'hc
`define MLA_EVEN_MASK    8'hfe
`define MLA_ODD_BIT      8'h01
`define MLA_ONE_W        16'h0001
`define MLA_ONE_B        8'h01
`define MLA_ONE_C        4'h1

`endif

//--- shared/mla_pkg.sv
// Purpose: Types shared by the transfer executor
// Assumes: Nothing
// Notes:   Numbers live in mla_regs.svh
package mla_pkg;

    typedef logic [7:0]  mla_byte_t;
    typedef logic [15:0] mla_word_t;

    // =================================================================
    // Sequencer states, one-hot
    typedef enum logic [10:0] {
        ST_IDLE = 11'h001,
        ST_PTR  = 11'h002,
        ST_RDH  = 11'h004,
        ST_RDL  = 11'h008,
        ST_ADR  = 11'h010,
        ST_MEMW = 11'h020,
        ST_SRC  = 11'h040,
        ST_WDST = 11'h080,
        ST_WH   = 11'h100,
        ST_WL   = 11'h200,
        ST_HOLD = 11'h400
    } mla_state_t;

    // =================================================================
    // Instruction classes
    typedef enum logic [1:0] {
        K_NONE  = 2'h0,
        K_LOAD  = 2'h1,
        K_STORE = 2'h2,
        K_WORD  = 2'h3
    } mla_kind_t;

endpackage : mla_pkg

//--- shared/mla_rf_if.sv
// Purpose: Register-file port between sequencer and storage
// Assumes: One read port with registered data, one write port
// Notes:   Read data appear the cycle after the address
`timescale 1ns/1ps
interface mla_rf_if;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       we;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    modport core (output rd_addr, output we, output wr_addr, output wr_data, input rd_data);
    modport mem  (input rd_addr, input we, input wr_addr, input wr_data, output rd_data);
endinterface : mla_rf_if

//--- hw/mla_regfile.sv
// Purpose: Byte-wide register file of the core
// Assumes: Single clock, one read and one write port
// Notes:   Read during write returns the old byte
`timescale 1ns/1ps
module mla_regfile #(
    parameter int DEPTH = 256
) (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    mla_rf_if.mem     rf
);
    logic [7:0] mem [DEPTH];

    // =================================================================
    // Storage, left uninitialised as in any RAM
    always_ff @(posedge core_clk_i) begin
        if (rf.we) begin
            mem[rf.wr_addr] <= rf.wr_data;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rf.rd_data <= 8'h00;
        end else begin
            rf.rd_data <= mem[rf.rd_addr];
        end
    end
endmodule : mla_regfile

//--- hw/mla_exec.sv
// Purpose: Executor for auto-indexed memory transfers and word moves
// Assumes: Memory answers a read one cycle after mem_req_o
// Notes:   One instruction at a time; start_i is ignored while busy
// Function
// - Opcode e2 loads the byte at the pair address into the destination, then decrements the pair, in 10 cycles.
// - The post-decrement load uses program memory for an even pair operand and data memory for an odd one.
// - Opcode e3 loads the byte at the pair address into the destination, then increments the pair, in 10 cycles.
// - The post-increment load uses program memory for an even pair operand and data memory for an odd one.
// - Opcode f2 decrements the pair first and then stores the source at the new address, in 14 cycles.
// - The pre-decrement store uses program memory for an even pair operand and data memory for an odd one.
// - Opcode f3 increments the pair first and then stores the source at the new address, in 14 cycles.
// - The pre-increment store uses program memory for an even pair operand and data memory for an odd one.
// - None of these transfers touches any status flag.
// - The source stays unchanged; only the destination and the address pair change.
// - Opcodes c4 and c5 copy a 16-bit pair or indirect source into a destination pair in 8 cycles.
// - Opcode c6 loads a 16-bit immediate into a destination pair in 8 cycles.
// - A word lands high byte at the even address and low byte at the next odd address.
// - On mask-ROM parts, stores into program memory are refused.
`timescale 1ns/1ps
`include "mla_regs.svh"
module mla_exec #(
    parameter logic [3:0] WORK_PAGE = 4'hc
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              start_i,
    input  wire mla_pkg::mla_byte_t opcode_i,
    input  wire mla_pkg::mla_byte_t opnd1_i,
    input  wire mla_pkg::mla_byte_t opnd2_i,
    input  wire mla_pkg::mla_byte_t opnd3_i,
    input  wire logic              mask_rom_i,
    input  wire mla_pkg::mla_byte_t mem_rdata_i,
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic                   mem_prog_o,
    output mla_pkg::mla_word_t     mem_addr_o,
    output mla_pkg::mla_byte_t     mem_wdata_o,
    output logic                   busy_o,
    output logic                   done_o,
    output logic                   illegal_o
);
    import mla_pkg::*;

    mla_rf_if rf ();

    mla_regfile #(.DEPTH(256)) u_rf (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rf         (rf)
    );

    // =================================================================
    // Decode helpers
    function automatic logic [3:0] op_len(input mla_byte_t op);
        case (op)
            `MLA_OP_LD_DEC, `MLA_OP_LD_INC:                     op_len = `MLA_CYC_LOAD;
            `MLA_OP_ST_DEC, `MLA_OP_ST_INC:                     op_len = `MLA_CYC_STORE;
            `MLA_OP_WORD_RR, `MLA_OP_WORD_IR, `MLA_OP_WORD_IMM: op_len = `MLA_CYC_WORD;
            default:                                            op_len = `MLA_CYC_NONE;
        endcase
    endfunction : op_len

    function automatic mla_kind_t op_kind(input mla_byte_t op);
        case (op)
            `MLA_OP_LD_DEC, `MLA_OP_LD_INC:                     op_kind = K_LOAD;
            `MLA_OP_ST_DEC, `MLA_OP_ST_INC:                     op_kind = K_STORE;
            `MLA_OP_WORD_RR, `MLA_OP_WORD_IR, `MLA_OP_WORD_IMM: op_kind = K_WORD;
            default:                                            op_kind = K_NONE;
        endcase
    endfunction : op_kind

    function automatic mla_byte_t rf_work(input logic [3:0] nib);
        rf_work = {WORK_PAGE, nib};
    endfunction : rf_work

    // Full register addresses with the escape nibble select a working register
    function automatic mla_byte_t rf_reg(input mla_byte_t b);
        rf_reg = (b[7:4] == `MLA_WORK_ESC) ? rf_work(b[3:0]) : b;
    endfunction : rf_reg

    function automatic mla_word_t adj(input mla_word_t w, input logic dec);
        adj = dec ? 16'(w - `MLA_ONE_W) : 16'(w + `MLA_ONE_W);
    endfunction : adj

    // =================================================================
    // Latched instruction and datapath
    mla_state_t  state;
    mla_kind_t   kind;
    mla_byte_t   opc;
    mla_byte_t   b1;
    mla_byte_t   b2;
    logic        dec;
    mla_word_t   w;
    mla_byte_t   ptr;
    mla_byte_t   wbase;
    logic [3:0]  cnt;
    logic [3:0]  len;
    logic        rom_mode;
    logic        strap_taken;
    logic [3:0]  pair_nib;
    mla_byte_t   pair_addr;
    mla_word_t   next_addr;
    logic        acc;

    assign pair_nib  = (kind == K_LOAD) ? b1[3:0] : b1[7:4];
    assign pair_addr = rf_work({pair_nib[3:1], 1'b0});
    assign next_addr = adj(w, dec);
    assign acc       = start_i && (state == ST_IDLE);

    // =================================================================
    // Strap caught once after reset release; it never changes mid-run
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rom_mode    <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            rom_mode    <= mask_rom_i;
            strap_taken <= 1'b1;
        end
    end

    // =================================================================
    // Cycle counter of the running instruction
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
        end else if (acc) begin
            cnt <= `MLA_ONE_C;
        end else if (state != ST_IDLE) begin
            cnt <= 4'(cnt + `MLA_ONE_C);
        end
    end

    // =================================================================
    // Register-file port; flags are never written by any path
    always_comb begin
        rf.rd_addr = pair_addr;
        rf.we      = 1'b0;
        rf.wr_addr = wbase;
        rf.wr_data = w[15:8];
        case (state)
            ST_PTR: rf.rd_addr = rf_reg(b1);
            ST_RDH: begin
                if (opc == `MLA_OP_WORD_IR) begin
                    rf.rd_addr = rf.rd_data;
                end else if (kind == K_WORD) begin
                    rf.rd_addr = rf_reg(b1) & `MLA_EVEN_MASK;
                end
            end
            ST_RDL: rf.rd_addr = 8'(ptr + `MLA_ONE_B);
            ST_ADR: rf.rd_addr = rf_work(b1[3:0]);
            ST_WDST: begin
                rf.we      = 1'b1;
                rf.wr_addr = rf_work(b1[7:4]);
                rf.wr_data = mem_rdata_i;
            end
            ST_WH: rf.we = 1'b1;
            ST_WL: begin
                rf.we      = 1'b1;
                rf.wr_addr = wbase | `MLA_ODD_BIT;
                rf.wr_data = w[7:0];
            end
            default: rf.we = 1'b0;
        endcase
    end

    // =================================================================
    // Sequencer
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state       <= ST_IDLE;
            kind        <= K_NONE;
            opc         <= 8'h00;
            b1          <= 8'h00;
            b2          <= 8'h00;
            dec         <= 1'b0;
            w           <= 16'h0000;
            ptr         <= 8'h00;
            wbase       <= 8'h00;
            len         <= 4'h0;
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_prog_o  <= 1'b0;
            mem_addr_o  <= 16'h0000;
            mem_wdata_o <= 8'h00;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            illegal_o   <= 1'b0;
        end else begin
            mem_req_o <= 1'b0;
            done_o    <= 1'b0;
            illegal_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_i && op_len(opcode_i) == `MLA_CYC_NONE) begin
                        illegal_o <= 1'b1;
                    end else if (start_i) begin
                        opc    <= opcode_i;
                        kind   <= op_kind(opcode_i);
                        b1     <= opnd1_i;
                        b2     <= opnd2_i;
                        dec    <= !opcode_i[0];
                        len    <= op_len(opcode_i);
                        busy_o <= 1'b1;
                        if (opcode_i == `MLA_OP_WORD_IMM) begin
                            w     <= {opnd2_i, opnd3_i};
                            wbase <= rf_reg(opnd1_i) & `MLA_EVEN_MASK;
                            state <= ST_WH;
                        end else if (opcode_i == `MLA_OP_WORD_IR) begin
                            state <= ST_PTR;
                        end else begin
                            state <= ST_RDH;
                        end
                    end
                end
                ST_PTR: state <= ST_RDH;
                ST_RDH: begin
                    ptr   <= rf.rd_addr;
                    state <= ST_RDL;
                end
                ST_RDL: begin
                    w[15:8] <= rf.rd_data;
                    state   <= ST_ADR;
                end
                ST_ADR: begin
                    w[7:0] <= rf.rd_data;
                    wbase  <= (kind == K_WORD) ? (rf_reg(b2) & `MLA_EVEN_MASK) : pair_addr;
                    if (kind == K_LOAD) begin
                        mem_req_o  <= 1'b1;
                        mem_we_o   <= 1'b0;
                        mem_prog_o <= !pair_nib[0];
                        mem_addr_o <= {w[15:8], rf.rd_data};
                        state      <= ST_MEMW;
                    end else if (kind == K_STORE) begin
                        state <= ST_SRC;
                    end else begin
                        state <= ST_WH;
                    end
                end
                ST_MEMW: state <= ST_WDST;
                ST_WDST: begin
                    w     <= next_addr;
                    state <= ST_WH;
                end
                ST_SRC: begin
                    // A refused store leaves pair and memory untouched
                    if (!pair_nib[0] && rom_mode) begin
                        illegal_o <= 1'b1;
                        busy_o    <= 1'b0;
                        state     <= ST_IDLE;
                    end else begin
                        mem_req_o   <= 1'b1;
                        mem_we_o    <= 1'b1;
                        mem_prog_o  <= !pair_nib[0];
                        mem_addr_o  <= next_addr;
                        mem_wdata_o <= rf.rd_data;
                        w           <= next_addr;
                        state       <= ST_WH;
                    end
                end
                ST_WH: state <= ST_WL;
                ST_WL: state <= ST_HOLD;
                ST_HOLD: begin
                    // Padding keeps documented instruction timing
                    if (cnt == 4'(len - `MLA_ONE_C)) begin
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state  <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_load_timing: assert property (acc && op_kind(opcode_i) == K_LOAD |-> ##10 done_o)
        else $error("load did not finish in 10 cycles");
    a_store_timing: assert property (acc && op_kind(opcode_i) == K_STORE
            && (opnd1_i[4] || !rom_mode) |-> ##14 done_o)
        else $error("store did not finish in 14 cycles");
    a_word_timing: assert property (acc && op_kind(opcode_i) == K_WORD
            |=> !done_o [*7] ##1 done_o)
        else $error("word move did not finish in 8 cycles");
    a_space_select: assert property (mem_req_o |-> mem_prog_o == !pair_nib[0])
        else $error("wrong memory space");
    a_rom_guard: assert property (mem_req_o && mem_we_o |-> !(mem_prog_o && rom_mode))
        else $error("program store on mask ROM part");
    a_load_update: assert property (state == ST_WH && kind == K_LOAD
            |-> w == adj(mem_addr_o, dec))
        else $error("pair not updated after load");
    a_store_pre: assert property (state == ST_WH && kind == K_STORE
            |-> w == mem_addr_o && mem_req_o && mem_we_o)
        else $error("store address is not the updated pair");
    a_src_kept: assert property (rf.we && kind == K_STORE
            |-> rf.wr_addr != rf_work(b1[3:0]) || pair_addr[3:1] == b1[3:1])
        else $error("store source overwritten");
    a_word_even: assert property (state == ST_WH |-> !rf.wr_addr[0] ##1 rf.wr_addr[0])
        else $error("word byte order wrong");
    a_dst_nibble: assert property (state == ST_WDST |-> rf.wr_addr == rf_work(b1[7:4]))
        else $error("load destination not the upper nibble");

    c_load: cover property (state == ST_WDST && mem_prog_o);
    c_store: cover property (mem_req_o && mem_we_o && !mem_prog_o);
    c_word: cover property (state == ST_WL && opc == `MLA_OP_WORD_IR);
    c_refused: cover property (illegal_o && kind == K_STORE);
endmodule : mla_exec

//--- tb/mla_mem_model.sv
// Purpose: Program and external data memory behind the executor
// Assumes: Read data valid in the cycle after a read request
// Notes:   Between reads the data bus toggles, so stale data is never trusted
`timescale 1ns/1ps
module mla_mem_model (
    input  wire logic               core_clk_i,
    input  wire logic               mem_req_i,
    input  wire logic               mem_we_i,
    input  wire logic               mem_prog_i,
    input  wire mla_pkg::mla_word_t mem_addr_i,
    input  wire mla_pkg::mla_byte_t mem_wdata_i,
    output mla_pkg::mla_byte_t      mem_rdata_o
);
    import mla_pkg::*;
    mla_byte_t prog_mem [mla_word_t];
    mla_byte_t data_mem [mla_word_t];

    initial mem_rdata_o = 8'h5a;

    // =================================================================
    // Access
    always @(posedge core_clk_i) begin
        if (mem_req_i && mem_we_i && mem_prog_i) prog_mem[mem_addr_i] = mem_wdata_i;
        if (mem_req_i && mem_we_i && !mem_prog_i) data_mem[mem_addr_i] = mem_wdata_i;
        if (mem_req_i && !mem_we_i) begin
            mem_rdata_o <= mem_prog_i ? prog_mem[mem_addr_i] : data_mem[mem_addr_i];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule : mla_mem_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the transfer executor
// Assumes: Fixed cycle counts, memory answers one cycle after a request
// Notes:   Driver queues expected events, a monitor pops them in order
`timescale 1ns/1ps
module tb_top;
    import mla_pkg::*;
    typedef struct {
        logic [1:0] kind;
        logic       we;
        logic       prog;
        mla_word_t  addr;
        mla_byte_t  data;
        int         cyc;
    } mla_note_t;

    logic      core_clk_i;
    logic      rst_n_i;
    logic      start_i;
    mla_byte_t opcode_i;
    mla_byte_t opnd1_i;
    mla_byte_t opnd2_i;
    mla_byte_t opnd3_i;
    logic      mask_rom_i;
    mla_byte_t mem_rdata_i;
    logic      mem_req_o;
    logic      mem_we_o;
    logic      mem_prog_o;
    mla_word_t mem_addr_o;
    mla_byte_t mem_wdata_o;
    logic      busy_o;
    logic      done_o;
    logic      illegal_o;
    mla_note_t notes[$];
    mla_note_t nt;
    int        error_cnt;
    int        checks_done;
    int        cyc;
    int        seed;
    mla_word_t a;
    mla_word_t w;
    mla_byte_t v;
    mla_byte_t op;
    mla_byte_t o1;

    mla_exec u_mla_exec (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (start_i),
        .opcode_i   (opcode_i),
        .opnd1_i    (opnd1_i),
        .opnd2_i    (opnd2_i),
        .opnd3_i    (opnd3_i),
        .mask_rom_i (mask_rom_i),
        .mem_rdata_i(mem_rdata_i),
        .mem_req_o  (mem_req_o),
        .mem_we_o   (mem_we_o),
        .mem_prog_o (mem_prog_o),
        .mem_addr_o (mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .busy_o     (busy_o),
        .done_o     (done_o),
        .illegal_o  (illegal_o)
    );

    mla_mem_model u_mla_mem_model (
        .core_clk_i (core_clk_i),
        .mem_req_i  (mem_req_o),
        .mem_we_i   (mem_we_o),
        .mem_prog_i (mem_prog_o),
        .mem_addr_i (mem_addr_o),
        .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i)
    );

    // =================================================================
    // Clock and cycle count
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) cyc <= cyc + 1;

    // =================================================================
    // Reporting
    task automatic fail(input string msg);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : fail

    task automatic results();
        if (notes.size() != 0) fail("events still pending");
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // =================================================================
    // Driver; hold keeps start up while busy, which must be ignored
    task automatic run(input mla_byte_t op, o1, o2, o3, input int n, input logic [1:0] k,
                       input logic m, input mla_word_t ad, input mla_byte_t d, input bit hold);
        mla_note_t e;
        start_i  <= 1'b1;
        opcode_i <= op;
        opnd1_i  <= o1;
        opnd2_i  <= o2;
        opnd3_i  <= o3;
        @(posedge core_clk_i);
        if (!hold) start_i <= 1'b0;
        #1;
        e = '{2'd0, op[4], op[4] ? ~o1[4] : ~o1[0], ad, d, 0};
        if (m) notes.push_back(e);
        e = '{k, 1'b0, 1'b0, 16'h0000, 8'h00, cyc + n - 1};
        notes.push_back(e);
        repeat (n - 1) @(posedge core_clk_i);
        start_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : run

    task automatic ld(input mla_byte_t op, o1, input mla_word_t ad);
        run(op, o1, 8'h00, 8'h00, 10, 2'd1, 1'b1, ad, 8'h00, 1'b0);
    endtask : ld

    task automatic st(input mla_byte_t op, o1, input mla_word_t ad, input mla_byte_t d,
                      input bit hold);
        run(op, o1, 8'h00, 8'h00, 14, 2'd1, 1'b1, ad, d, hold);
    endtask : st

    task automatic wd(input mla_byte_t op, o1, o2, o3);
        run(op, o1, o2, o3, 8, 2'd1, 1'b0, 16'h0000, 8'h00, 1'b0);
    endtask : wd

    // =================================================================
    // Monitor: every request or completion consumes the oldest note
    always @(negedge core_clk_i) begin
        if (rst_n_i && (mem_req_o || done_o || illegal_o)) begin
            checks_done++;
            if (notes.size() == 0) begin
                fail("unexpected event");
            end else begin
                nt = notes.pop_front();
                if (nt.kind == 2'd0) begin
                    if (!(mem_req_o === 1'b1 && mem_we_o === nt.we && mem_prog_o === nt.prog
                          && mem_addr_o === nt.addr && (!nt.we || mem_wdata_o === nt.data)
                          && busy_o === 1'b1))
                        fail("memory access");
                end else if (nt.kind == 2'd1 ? done_o !== 1'b1 : illegal_o !== 1'b1) begin
                    fail("completion kind");
                end else if (cyc != nt.cyc) begin
                    fail("completion cycle");
                end else if (busy_o !== 1'b0) begin
                    fail("busy after completion");
                end
            end
        end
    end

    // =================================================================
    // Scenarios
    initial begin
        seed = 72;
        rst_n_i = 1'b0;
        start_i = 1'b0;
        opcode_i = 8'h00;
        opnd1_i = 8'h00;
        opnd2_i = 8'h00;
        opnd3_i = 8'h00;
        mask_rom_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        for (int i = 0; i < 4; i++) begin
            a = $random(seed);
            v = $random(seed);
            if (i[0]) u_mla_mem_model.data_mem[a] = v;
            else u_mla_mem_model.prog_mem[a] = v;
            wd(8'hc6, 8'hc6, a[15:8], a[7:0]);
            op = i[1] ? 8'he3 : 8'he2;
            ld(op, {4'h8, 3'b011, i[0]}, a);
            op = i[1] ? 8'hf3 : 8'hf2;
            o1 = {3'b011, i[0], 4'h8};
            w = i[1] ? a + 16'h0002 : a - 16'h0002;
            st(op, o1, w, v, 1'b0);
            w = i[1] ? w + 16'h0001 : w - 16'h0001;
            st(op, o1, w, v, 1'b1);
        end
        wd(8'hc6, 8'hc6, 8'h21, 8'hff);
        st(8'hf3, 8'h68, 16'h2200, v, 1'b0);
        wd(8'hc6, 8'hc6, 8'h30, 8'h00);
        st(8'hf2, 8'h78, 16'h2fff, v, 1'b0);
        w = $random(seed);
        wd(8'hc6, 8'hc6, w[15:8], w[7:0]);
        wd(8'hc4, 8'hc6, 8'hc4, 8'h00);
        st(8'hf3, 8'h46, w + 16'h0001, w[15:8], 1'b0);
        st(8'hf3, 8'h47, w + 16'h0002, w[7:0], 1'b0);
        wd(8'hc6, 8'hca, 8'h00, 8'hc4);
        wd(8'hc5, 8'hcb, 8'hc0, 8'h00);
        st(8'hf2, 8'h08, w + 16'h0001, v, 1'b0);
        run(8'h47, 8'h00, 8'h00, 8'h00, 1, 2'd2, 1'b0, 16'h0000, 8'h00, 1'b0);
        // Strap is only read after reset, so a second reset selects mask ROM
        rst_n_i <= 1'b0;
        mask_rom_i <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        a = $random(seed);
        v = $random(seed);
        u_mla_mem_model.prog_mem[a] = v;
        wd(8'hc6, 8'hc6, a[15:8], a[7:0]);
        ld(8'he2, 8'h86, a);
        run(8'hf3, 8'h68, 8'h00, 8'h00, 5, 2'd2, 1'b0, 16'h0000, 8'h00, 1'b0);
        st(8'hf3, 8'h78, a, v, 1'b0);
        results();
    end

    // =================================================================
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fail("watchdog expired");
        results();
    end
endmodule : tb_top
